// ==== core/pag_port_a.v ====
// Port A general-purpose I/O with analog select and pin steering
// Summary of operation
// - Eight pins, each digital in or out
// - Direction one tristates, zero drives latch
// - Read gives pins, write loads latch
// - Writes load the whole latch from the bus
// - Direction controls drivers even when analog
// - Analog pins read back as zero
// - Analog bits 5..0 select analog per pin
// - Analog select never affects digital output
// - Enabled peripheral may claim the pin
// - Steering bit 1 picks slave-select pin
// - Steering bit 0 picks capture pin
// - Timer0 clock works in any direction
// - Bit 3 also feeds ADC reference
`timescale 1ns/100ps
`default_nettype none
`include "pag_map.vh"
module pag_port_a #(
  parameter WIDTH = 8
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire [WIDTH-1:0] pad_in,
  output wire [WIDTH-1:0] pad_out,
  output wire [WIDTH-1:0] pad_oe_n_out,
  input wire [WIDTH-1:0] periph_own_in,
  input wire [WIDTH-1:0] periph_data_in,
  input wire [WIDTH-1:0] periph_oe_n_in,
  output wire [5:0] analog_sel_out,
  output wire adc_vref_out,
  output wire timer_zero_ext_clock_out,
  output wire ss_out,
  input wire pc_bit1_in,
  input wire pb_bit3_in,
  input wire capture_unit_two_out_in,
  input wire capture_unit_two_oe_n_in,
  output wire capture_unit_two_capture_out,
  output wire pc_bit1_o_out,
  output wire pc_bit1_oe_n_out,
  output wire pb_bit3_o_out,
  output wire pb_bit3_oe_n_out
);
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n = rst_s2_r;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  reg [WIDTH-1:0] latch_r;
  reg [WIDTH-1:0] dir_r;
  reg [7:0] ansel_r;
  reg [1:0] steer_r;
  wire [WIDTH-1:0] ansel_w = ansel_r[WIDTH-1:0];
  wire [WIDTH-1:0] pin_digital;
  wire [7:0] pins8 = pin_digital[7:0];

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      assign pad_out[i] = periph_own_in[i] ? periph_data_in[i] : latch_r[i];
      assign pad_oe_n_out[i] = periph_own_in[i] ? periph_oe_n_in[i] : dir_r[i];
      assign pin_digital[i] = pad_in[i] & ~ansel_w[i];
    end
  endgenerate

  assign adc_vref_out = pad_in[`PAG_BIT_VREF];
  // pad level clocks timer, any direction
  assign timer_zero_ext_clock_out = pad_in[`PAG_BIT_T0CLK];
  assign analog_sel_out = ansel_r[5:0];

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= `PAG_RST_LATCH;
      dir_r <= `PAG_RST_DIR;
      ansel_r <= `PAG_RST_ANSEL;
      steer_r <= `PAG_RST_STEER;
    end else if (wr_in) begin
      if (addr_in == `PAG_OFS_DATA) begin
        // byte write: all bits from bus
        latch_r <= wdata_in[WIDTH-1:0];
      end else if (addr_in == `PAG_OFS_DIR) begin
        dir_r <= wdata_in[WIDTH-1:0];
      end else if (addr_in == `PAG_OFS_ANSEL) begin
        ansel_r <= wdata_in & `PAG_ANSEL_MASK;
      end else if (addr_in == `PAG_OFS_STEER) begin
        steer_r <= wdata_in[1:0];
      end
    end
  end

  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      if (addr_in == `PAG_OFS_DATA) begin
        rdata_out <= pins8;
      end else if (addr_in == `PAG_OFS_DIR) begin
        rdata_out <= dir_r;
      end else if (addr_in == `PAG_OFS_ANSEL) begin
        rdata_out <= ansel_r;
      end else if (addr_in == `PAG_OFS_STEER) begin
        rdata_out <= {6'h00, steer_r};
      end else begin
        rdata_out <= 8'h00;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end

  pag_pin_mux u_mux (
    .steer_in(steer_r),
    .pa_digital_in(pins8),
    .pc_bit1_in(pc_bit1_in),
    .pb_bit3_in(pb_bit3_in),
    .capture_unit_two_out_in(capture_unit_two_out_in),
    .capture_unit_two_oe_n_in(capture_unit_two_oe_n_in),
    .ss_out(ss_out),
    .capture_unit_two_capture_out(capture_unit_two_capture_out),
    .pc_bit1_o_out(pc_bit1_o_out),
    .pc_bit1_oe_n_out(pc_bit1_oe_n_out),
    .pb_bit3_o_out(pb_bit3_o_out),
    .pb_bit3_oe_n_out(pb_bit3_oe_n_out)
  );
endmodule
`default_nettype wire

// ==== core/pag_map.vh ====
// Register offsets, field positions and reset values for the port A block
`ifndef PAG_MAP_VH
`define PAG_MAP_VH
`define PAG_OFS_DATA 4'h0
`define PAG_OFS_DIR 4'h1
`define PAG_OFS_ANSEL 4'h2
`define PAG_OFS_STEER 4'h3
`define PAG_RST_DIR 8'hFF
`define PAG_RST_ANSEL 8'h3F
`define PAG_RST_LATCH 8'h00
`define PAG_RST_STEER 2'h0
`define PAG_ANSEL_MASK 8'h3F
`define PAG_STEER_CCP_BIT 0
`define PAG_STEER_SS_BIT 1
`define PAG_BIT_SS_ALT 0
`define PAG_BIT_VREF 3
`define PAG_BIT_T0CLK 4
`define PAG_BIT_SS_MAIN 5
`endif

// ==== core/pag_pin_mux.v ====
// Pin steering for the slave-select input and capture unit two
`timescale 1ns/100ps
`default_nettype none
`include "pag_map.vh"
module pag_pin_mux (
  input wire [1:0] steer_in,
  input wire [7:0] pa_digital_in,
  input wire pc_bit1_in,
  input wire pb_bit3_in,
  input wire capture_unit_two_out_in,
  input wire capture_unit_two_oe_n_in,
  output wire ss_out,
  output wire capture_unit_two_capture_out,
  output wire pc_bit1_o_out,
  output wire pc_bit1_oe_n_out,
  output wire pb_bit3_o_out,
  output wire pb_bit3_oe_n_out
);
  wire ss_alt = steer_in[`PAG_STEER_SS_BIT];
  wire ccp_alt = steer_in[`PAG_STEER_CCP_BIT];
  assign ss_out = ss_alt ? pa_digital_in[`PAG_BIT_SS_ALT] : pa_digital_in[`PAG_BIT_SS_MAIN];
  assign capture_unit_two_capture_out = ccp_alt ? pb_bit3_in : pc_bit1_in;
  assign pc_bit1_o_out = capture_unit_two_out_in;
  assign pb_bit3_o_out = capture_unit_two_out_in;
  // Unselected pin stays released
  assign pc_bit1_oe_n_out = ccp_alt ? 1'b1 : capture_unit_two_oe_n_in;
  assign pb_bit3_oe_n_out = ccp_alt ? capture_unit_two_oe_n_in : 1'b1;
endmodule
`default_nettype wire

// ==== tb/pag_port_a_sva.sv ====
// Port-level assertions for the port A block
`timescale 1ns/100ps
`default_nettype none
module pag_sva(input wire logic core_clk_in, rst_n_in, wr_in, rd_in, adc_vref_out, timer_zero_ext_clock_out,
  input wire logic [3:0] addr_in, input wire logic [5:0] analog_sel_out,
  input wire logic [7:0] wdata_in, rdata_out, pad_in, pad_out, pad_oe_n_out, periph_own_in, periph_data_in);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_dir; wr_in && addr_in == 4'h1 && periph_own_in == 8'h00 |=> pad_oe_n_out == $past(wdata_in); endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_lat; wr_in && addr_in == 4'h0 && periph_own_in == 8'h00 |=> pad_out == $past(wdata_in); endproperty
  a_lat: assert property (p_lat) else $error("latch not driven");
  property p_rd; rd_in && addr_in == 4'h0 |=> rdata_out == ($past(pad_in) & ~{2'h0, $past(analog_sel_out)}); endproperty
  a_rd: assert property (p_rd) else $error("pin read wrong");
  property p_hold; !rd_in |=> rdata_out == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("read data lingers");
  property p_ans; wr_in && addr_in == 4'h2 |=> analog_sel_out == $past(wdata_in[5:0]); endproperty
  a_ans: assert property (p_ans) else $error("analog select wrong");
  property p_raw; timer_zero_ext_clock_out == pad_in[4] && adc_vref_out == pad_in[3]; endproperty
  a_raw: assert property (p_raw) else $error("raw pin feed wrong");
  property p_own; ((pad_out ^ periph_data_in) & periph_own_in) == 8'h00; endproperty
  a_own: assert property (p_own) else $error("peripheral drive lost");
  property p_rst; $rose(rst_n_in) |-> pad_oe_n_out == 8'hFF && analog_sel_out == 6'h3F; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind pag_port_a pag_sva u_pag_sva(.*);
`default_nettype wire

// ==== tb/pag_pads.sv ====
// Pad model: driven pins follow the block, released pins the board
`timescale 1ns/100ps
`default_nettype none
module pag_pads(input wire logic [7:0] o_in, input wire logic [7:0] oe_n_in, input wire logic [7:0] ext_in,
  output logic [7:0] lvl_out);
  assign lvl_out = (o_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Register-level bench for the port A block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic [7:0] wdata_in, rdata_out, pad_in, pad_out, pad_oe_n_out, periph_own_in, periph_data_in, periph_oe_n_in, ext;
  logic [5:0] analog_sel_out;
  logic [3:0] addr_in;
  logic core_clk_in, rst_n_in, wr_in, rd_in, pc_bit1_in, pb_bit3_in, capture_unit_two_out_in, capture_unit_two_oe_n_in, adc_vref_out;
  logic timer_zero_ext_clock_out, ss_out, capture_unit_two_capture_out, pc_bit1_o_out, pc_bit1_oe_n_out, pb_bit3_o_out;
  logic pb_bit3_oe_n_out;
  int n_fail = 0, check_count = 0;
  pag_port_a u_pag_port_a(.*);
  pag_pads u_pag_pads(.o_in(pad_out), .oe_n_in(pad_oe_n_out), .ext_in(ext), .lvl_out(pad_in));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge core_clk_in) wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge core_clk_in) rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    {addr_in, wdata_in, wr_in, rd_in, rst_n_in, pc_bit1_in, pb_bit3_in, capture_unit_two_out_in} = '0;
    {periph_own_in, periph_data_in, periph_oe_n_in, capture_unit_two_oe_n_in, ext} = {24'h0000FF, 1'b1, 8'hA5};
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rd(4'h1, 8'hFF);
    rd(4'h2, 8'h3F);
    rd(4'h3, 8'h00);
    rd(4'h0, 8'h80);
    // analog select cleared so all pins read digital here
    wr(4'h2, 8'h00);
    rd(4'h0, 8'hA5);
    wr(4'h0, 8'hC3);
    wr(4'h1, 8'h0F);
    rd(4'h0, 8'hC5);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h3F);
    rd(4'h0, 8'hC0);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h03);
    chk({7'h0, ss_out}, 8'h01);
    {pc_bit1_in, pb_bit3_in} <= 2'b01;
    wr(4'h3, 8'h00);
    chk({7'h0, ss_out}, 8'h00);
    chk({7'h0, capture_unit_two_capture_out}, 8'h00);
    wr(4'h3, 8'h01);
    chk({7'h0, capture_unit_two_capture_out}, 8'h01);
    @(posedge core_clk_in) {periph_own_in, periph_oe_n_in, capture_unit_two_out_in, capture_unit_two_oe_n_in} <= {8'h01, 8'h00, 2'b10};
    #1 chk(pad_out, 8'hC2);
    chk(pad_oe_n_out, 8'h0E);
    chk({5'h0, pb_bit3_o_out, pb_bit3_oe_n_out, pc_bit1_oe_n_out}, 8'h05);
    @(posedge core_clk_in) {periph_own_in, periph_oe_n_in} <= {8'h00, 8'hFF};
    wr(4'h0, 8'hD3);
    chk({7'h0, timer_zero_ext_clock_out}, 8'h01);
    chk({7'h0, adc_vref_out}, 8'h00);
    chk({2'h0, analog_sel_out}, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    final_report();
  end
  initial begin
    #20000 n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
